// [hdl/timer_block_consts.vh]
// Constant definitions shared by the timer block design files.
`ifndef TIMER_BLOCK_CONSTS_VH
`define TIMER_BLOCK_CONSTS_VH

// Special-function register addresses.
`define ADDR_TIMER3_CONFIG 8'h84
`define ADDR_TIMER3_TARGET_HIGH 8'h85
`define ADDR_TIMER3_TARGET_LOW 8'h86
`define ADDR_TIMER_CONTROL_FLAGS 8'h88
`define ADDR_TIMER_MODE_SELECT 8'h89
`define ADDR_TIMER0_COUNT_LOW 8'h8A
`define ADDR_TIMER1_COUNT_LOW 8'h8B
`define ADDR_TIMER0_COUNT_HIGH 8'h8C
`define ADDR_TIMER1_COUNT_HIGH 8'h8D

// Reset values.
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000

// Third timer configuration bit positions.
`define BIT_T3_CLOCK_PICK 2
`define BIT_T3_AUTO_RELOAD 1
`define BIT_T3_RUN 0

// Control flag bit positions.
`define BIT_T1_OVERFLOW 7
`define BIT_T1_RUN 6
`define BIT_T0_OVERFLOW 5
`define BIT_T0_RUN 4

// Mode field positions.
`define T1_MODE_HI 5
`define T1_MODE_LO 4
`define T0_MODE_HI 1
`define T0_MODE_LO 0

// Mode encodings.
`define MODE_13BIT 2'b00
`define MODE_16BIT 2'b01
`define MODE_8BIT_RELOAD 2'b10
`define MODE_SPLIT 2'b11

// Prescaler divisors of the fast base clock.
`define DIV_FAST 4'h4
`define DIV_SLOW 4'hC
`define DIV_CLASSIC 4'hC

`endif

// [hdl/tick_divider.v]
// Divider that emits a one-cycle enable pulse every DIV clock cycles.
`timescale 1ns/1ps
`default_nettype none
`include "timer_block_consts.vh"

module tick_divider #(
    parameter [3:0] DIV = `DIV_SLOW
) (
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Enable pulse.
    output wire tick
);

    localparam [3:0] LAST = DIV - 4'h1;

    reg [3:0] count_reg;

    always @(posedge clk) begin
        if (reset) begin
            count_reg <= 4'h0;
        end else if (count_reg == LAST) begin
            count_reg <= 4'h0;
        end else begin
            count_reg <= count_reg + 4'h1;
        end
    end

    assign tick = (count_reg == LAST);

endmodule
`default_nettype wire

// [hdl/third_timer_core.v]
// Counter of the third timer that counts prescaled ticks up to a target.
`timescale 1ns/1ps
`default_nettype none
`include "timer_block_consts.vh"

module third_timer_core (
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Control.
    input wire tick,
    input wire run,
    input wire restart,
    input wire [15:0] target,
    // Status.
    output reg [15:0] count,
    output reg done
);

    always @(posedge clk) begin
        if (reset) begin
            count <= `RESET_WORD;
            done <= 1'b0;
        end else if (restart || !run) begin
            // A write during counting starts the period again from zero.
            count <= `RESET_WORD;
            done <= 1'b0;
        end else if (tick) begin
            if (count == target) begin
                count <= `RESET_WORD;
                done <= 1'b1;
            end else begin
                count <= count + 16'h0001;
                done <= 1'b0;
            end
        end else begin
            done <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// [hdl/timer_block.v]
// Timer block with two classic timers and a 16-bit third timer.
//
// Function
// - Clock pick: set gives /4, clear /12.
// - Reload bit: one automatic, zero manual.
// - Run bit one starts, zero stops.
// - Manual mode clears run at period end.
// - Run bit write mid-count restarts count.
// - Target byte write mid-count restarts count.
// - Timer1 or split upper byte overflow sets flag.
// - Timer1 run starts timer1 or split upper.
// - Timer0 overflow sets its overflow flag.
// - Timer0 run bit starts timer0 counting.
// - Timer1 mode field picks four modes.
// - Timer0 mode field uses same encoding.
// - Count bytes readable, writable, reset zero.
// - Automatic mode keeps run, restarts from zero.
`timescale 1ns/1ps
`default_nettype none
`include "timer_block_consts.vh"

module timer_block (
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Special-function register port.
    input wire [7:0] sfr_addr,
    input wire sfr_wr_en,
    input wire sfr_rd_en,
    input wire [7:0] sfr_wdata,
    output reg [7:0] sfr_rdata,
    // Events toward the interrupt logic.
    output reg timer0_event,
    output reg timer1_event,
    output reg timer3_event
);

    // Steps a classic timer one count: returns overflow, high and low bytes.
    function [16:0] classic_step;
        input [1:0] mode;
        input [7:0] hi;
        input [7:0] lo;
        reg [13:0] c13;
        reg [16:0] c16;
        reg [8:0] c8;
        begin
            c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
            c16 = {1'b0, hi, lo} + 17'h00001;
            c8 = {1'b0, lo} + 9'h001;
            case (mode)
                `MODE_13BIT: begin
                    classic_step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
                end
                `MODE_16BIT: begin
                    classic_step = c16;
                end
                `MODE_8BIT_RELOAD: begin
                    classic_step = {c8[8], hi, (c8[8] ? hi : c8[7:0])};
                end
                default: begin
                    classic_step = {c8[8], hi, c8[7:0]};
                end
            endcase
        end
    endfunction

    // Register storage.
    reg t3_clock_pick_reg;
    reg t3_auto_reload_reg;
    reg t3_run_reg;
    reg [7:0] t3_target_high_reg;
    reg [7:0] t3_target_low_reg;
    reg t1_overflow_reg;
    reg t1_run_reg;
    reg t0_overflow_reg;
    reg t0_run_reg;
    reg [1:0] t1_mode_reg;
    reg [1:0] t0_mode_reg;
    reg [7:0] t0_low_reg;
    reg [7:0] t0_high_reg;
    reg [7:0] t1_low_reg;
    reg [7:0] t1_high_reg;

    // Write strobes.
    wire wr_t3_config = sfr_wr_en && (sfr_addr == `ADDR_TIMER3_CONFIG);
    wire wr_t3_high = sfr_wr_en && (sfr_addr == `ADDR_TIMER3_TARGET_HIGH);
    wire wr_t3_low = sfr_wr_en && (sfr_addr == `ADDR_TIMER3_TARGET_LOW);
    wire wr_control = sfr_wr_en && (sfr_addr == `ADDR_TIMER_CONTROL_FLAGS);
    wire wr_mode = sfr_wr_en && (sfr_addr == `ADDR_TIMER_MODE_SELECT);
    wire wr_t0_low = sfr_wr_en && (sfr_addr == `ADDR_TIMER0_COUNT_LOW);
    wire wr_t1_low = sfr_wr_en && (sfr_addr == `ADDR_TIMER1_COUNT_LOW);
    wire wr_t0_high = sfr_wr_en && (sfr_addr == `ADDR_TIMER0_COUNT_HIGH);
    wire wr_t1_high = sfr_wr_en && (sfr_addr == `ADDR_TIMER1_COUNT_HIGH);

    // Prescaler ticks taken from the fast base clock.
    wire tick_fast;
    wire tick_slow;
    wire tick_classic;

    tick_divider #(.DIV(`DIV_FAST)) div_fast (
        .clk(clk),
        .reset(reset),
        .tick(tick_fast)
    );

    tick_divider #(.DIV(`DIV_SLOW)) div_slow (
        .clk(clk),
        .reset(reset),
        .tick(tick_slow)
    );

    tick_divider #(.DIV(`DIV_CLASSIC)) div_classic (
        .clk(clk),
        .reset(reset),
        .tick(tick_classic)
    );

    // Third timer.
    wire t3_tick = t3_clock_pick_reg ? tick_fast : tick_slow;
    wire t3_restart = wr_t3_config || wr_t3_high || wr_t3_low;
    wire [15:0] t3_count;
    wire t3_done;

    third_timer_core t3_core (
        .clk(clk),
        .reset(reset),
        .tick(t3_tick),
        .run(t3_run_reg),
        .restart(t3_restart),
        .target({t3_target_high_reg, t3_target_low_reg}),
        .count(t3_count),
        .done(t3_done)
    );

    always @(posedge clk) begin
        if (reset) begin
            t3_clock_pick_reg <= 1'b0;
            t3_auto_reload_reg <= 1'b0;
            t3_run_reg <= 1'b0;
            t3_target_high_reg <= `RESET_BYTE;
            t3_target_low_reg <= `RESET_BYTE;
        end else begin
            if (wr_t3_config) begin
                t3_clock_pick_reg <= sfr_wdata[`BIT_T3_CLOCK_PICK];
                t3_auto_reload_reg <= sfr_wdata[`BIT_T3_AUTO_RELOAD];
                t3_run_reg <= sfr_wdata[`BIT_T3_RUN];
            end else if (t3_done && !t3_auto_reload_reg) begin
                t3_run_reg <= 1'b0;
            end
            if (wr_t3_high) begin
                t3_target_high_reg <= sfr_wdata;
            end
            if (wr_t3_low) begin
                t3_target_low_reg <= sfr_wdata;
            end
        end
    end

    // Classic timer stepping.
    wire t0_split = (t0_mode_reg == `MODE_SPLIT);
    wire t0_low_go = tick_classic && t0_run_reg;
    wire t0_high_go = tick_classic && t1_run_reg && t0_split;
    wire t1_go = tick_classic && t1_run_reg && (t1_mode_reg != `MODE_SPLIT);
    wire [16:0] t0_step = classic_step(t0_mode_reg, t0_high_reg, t0_low_reg);
    wire [16:0] t0_upper_step = classic_step(`MODE_SPLIT, 8'h00, t0_high_reg);
    wire [16:0] t1_step = classic_step(t1_mode_reg, t1_high_reg, t1_low_reg);
    wire t0_overflow_hit = t0_low_go && t0_step[16];
    wire t0_upper_hit = t0_high_go && t0_upper_step[16];
    wire t1_overflow_hit = (t1_go && t1_step[16]) || t0_upper_hit;

    // Timer0 count bytes; a software write wins over a count step.
    always @(posedge clk) begin
        if (reset) begin
            t0_low_reg <= `RESET_BYTE;
            t0_high_reg <= `RESET_BYTE;
        end else begin
            if (wr_t0_low) begin
                t0_low_reg <= sfr_wdata;
            end else if (t0_low_go) begin
                t0_low_reg <= t0_step[7:0];
            end
            if (wr_t0_high) begin
                t0_high_reg <= sfr_wdata;
            end else if (t0_split) begin
                if (t0_high_go) begin
                    t0_high_reg <= t0_upper_step[7:0];
                end
            end else if (t0_low_go) begin
                t0_high_reg <= t0_step[15:8];
            end
        end
    end

    // Timer1 count bytes; in split mode timer1 holds its count.
    always @(posedge clk) begin
        if (reset) begin
            t1_low_reg <= `RESET_BYTE;
            t1_high_reg <= `RESET_BYTE;
        end else begin
            if (wr_t1_low) begin
                t1_low_reg <= sfr_wdata;
            end else if (t1_go) begin
                t1_low_reg <= t1_step[7:0];
            end
            if (wr_t1_high) begin
                t1_high_reg <= sfr_wdata;
            end else if (t1_go) begin
                t1_high_reg <= t1_step[15:8];
            end
        end
    end

    // Control flags and mode select; a hardware set wins over a clear.
    always @(posedge clk) begin
        if (reset) begin
            t1_overflow_reg <= 1'b0;
            t1_run_reg <= 1'b0;
            t0_overflow_reg <= 1'b0;
            t0_run_reg <= 1'b0;
            t1_mode_reg <= `MODE_13BIT;
            t0_mode_reg <= `MODE_13BIT;
        end else begin
            if (wr_control) begin
                t1_run_reg <= sfr_wdata[`BIT_T1_RUN];
                t0_run_reg <= sfr_wdata[`BIT_T0_RUN];
                t1_overflow_reg <= sfr_wdata[`BIT_T1_OVERFLOW] || t1_overflow_hit;
                t0_overflow_reg <= sfr_wdata[`BIT_T0_OVERFLOW] || t0_overflow_hit;
            end else begin
                t1_overflow_reg <= t1_overflow_reg || t1_overflow_hit;
                t0_overflow_reg <= t0_overflow_reg || t0_overflow_hit;
            end
            if (wr_mode) begin
                t1_mode_reg <= sfr_wdata[`T1_MODE_HI:`T1_MODE_LO];
                t0_mode_reg <= sfr_wdata[`T0_MODE_HI:`T0_MODE_LO];
            end
        end
    end

    // Event pulses toward the interrupt logic.
    always @(posedge clk) begin
        if (reset) begin
            timer0_event <= 1'b0;
            timer1_event <= 1'b0;
            timer3_event <= 1'b0;
        end else begin
            timer0_event <= t0_overflow_hit;
            timer1_event <= t1_overflow_hit;
            timer3_event <= t3_done;
        end
    end

    // Read data; unmapped addresses and reserved bits read as zero.
    reg [7:0] read_value;

    always @* begin
        read_value = 8'h00;
        case (sfr_addr)
            `ADDR_TIMER3_CONFIG: begin
                read_value[`BIT_T3_CLOCK_PICK] = t3_clock_pick_reg;
                read_value[`BIT_T3_AUTO_RELOAD] = t3_auto_reload_reg;
                read_value[`BIT_T3_RUN] = t3_run_reg;
            end
            `ADDR_TIMER3_TARGET_HIGH: begin
                read_value = t3_target_high_reg;
            end
            `ADDR_TIMER3_TARGET_LOW: begin
                read_value = t3_target_low_reg;
            end
            `ADDR_TIMER_CONTROL_FLAGS: begin
                read_value[`BIT_T1_OVERFLOW] = t1_overflow_reg;
                read_value[`BIT_T1_RUN] = t1_run_reg;
                read_value[`BIT_T0_OVERFLOW] = t0_overflow_reg;
                read_value[`BIT_T0_RUN] = t0_run_reg;
            end
            `ADDR_TIMER_MODE_SELECT: begin
                read_value[`T1_MODE_HI:`T1_MODE_LO] = t1_mode_reg;
                read_value[`T0_MODE_HI:`T0_MODE_LO] = t0_mode_reg;
            end
            `ADDR_TIMER0_COUNT_LOW: begin
                read_value = t0_low_reg;
            end
            `ADDR_TIMER1_COUNT_LOW: begin
                read_value = t1_low_reg;
            end
            `ADDR_TIMER0_COUNT_HIGH: begin
                read_value = t0_high_reg;
            end
            `ADDR_TIMER1_COUNT_HIGH: begin
                read_value = t1_high_reg;
            end
            default: begin
                read_value = 8'h00;
            end
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            sfr_rdata <= `RESET_BYTE;
        end else if (sfr_rd_en) begin
            sfr_rdata <= read_value;
        end
    end

endmodule
`default_nettype wire

// [sim/timer_block_assertions.sv]
// Concurrent checks on the timer block register port and event outputs.
`timescale 1ns/1ps
`default_nettype none
`include "timer_block_consts.vh"
module timer_block_assertions (
    // Clock and reset.
    input wire clk,
    input wire reset,
    // Register port.
    input wire [7:0] sfr_addr,
    input wire sfr_wr_en,
    input wire sfr_rd_en,
    input wire [7:0] sfr_wdata,
    input wire [7:0] sfr_rdata,
    // Events.
    input wire timer0_event,
    input wire timer1_event,
    input wire timer3_event
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire rd_only = sfr_rd_en && !sfr_wr_en;
    wire wr_cfg = sfr_wr_en && sfr_addr == `ADDR_TIMER3_CONFIG;
    wire rd_cfg = rd_only && sfr_addr == `ADDR_TIMER3_CONFIG;
    wire wr_mode = sfr_wr_en && sfr_addr == `ADDR_TIMER_MODE_SELECT;
    wire rd_mode = rd_only && sfr_addr == `ADDR_TIMER_MODE_SELECT;
    a_t3_spacing: assert property (timer3_event |=> !timer3_event [*3])
        else $error("third timer events closer than four cycles");
    a_t0_spacing: assert property (timer0_event |=> !timer0_event [*8])
        else $error("timer0 events closer than the tick period");
    a_t1_spacing: assert property (timer1_event |=> !timer1_event [*8])
        else $error("timer1 events closer than the tick period");
    a_rdata_hold: assert property (!sfr_rd_en |=> $stable(sfr_rdata))
        else $error("read data changed without a read");
    a_unmapped_zero: assert property (rd_only && sfr_addr == 8'h87 |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_mode_readback: assert property (wr_mode ##1 rd_mode |=>
        sfr_rdata == ($past(sfr_wdata, 2) & 8'h33)) else $error("mode readback wrong");
    a_cfg_readback: assert property (wr_cfg ##1 rd_cfg |=>
        sfr_rdata == ($past(sfr_wdata, 2) & 8'h07)) else $error("config readback wrong");
    a_timer_control_flags_low: assert property (rd_only && sfr_addr == 8'h88 |=> sfr_rdata[3:0] == 4'h0)
        else $error("control low bits not zero");
    cover property (timer0_event);
    cover property (timer1_event);
    cover property (timer3_event);
    cover property (wr_cfg ##[1:100] timer3_event);
endmodule
bind timer_block timer_block_assertions chk_u (.clk(clk), .reset(reset),
    .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer0_event(timer0_event),
    .timer1_event(timer1_event), .timer3_event(timer3_event));
`default_nettype wire

// [sim/timer_block_tb_top.sv]
// Self-checking bench for the timer block.
`timescale 1ns/1ps
`default_nettype none
`include "timer_block_consts.vh"
module timer_block_tb_top;
    // Design signals.
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr_en = 1'b0;
    logic sfr_rd_en = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    wire [7:0] sfr_rdata;
    wire timer0_event;
    wire timer1_event;
    wire timer3_event;
    // Bench state.
    int err_count = 0;
    int checks = 0;
    int n;
    int t;
    int div;
    logic [7:0] rv;
    logic [7:0] regs [10] = '{8'h84, 8'h85, 8'h86, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C,
        8'h8D, 8'h87};
    logic [7:0] mask [10] = '{8'h07, 8'hFF, 8'hFF, 8'hF0, 8'h33, 8'hFF, 8'hFF, 8'hFF,
        8'hFF, 8'h00};
    timer_block dut_u (.clk(clk), .reset(reset), .sfr_addr(sfr_addr),
        .sfr_wr_en(sfr_wr_en), .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .timer0_event(timer0_event), .timer1_event(timer1_event),
        .timer3_event(timer3_event));
    always #10 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr_en = 1'b1;
        sfr_rd_en = 1'b0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        sfr_addr = a;
        sfr_rd_en = 1'b1;
        sfr_wr_en = 1'b0;
        @(negedge clk);
        d = sfr_rdata;
    endtask
    task automatic wait_ev(input int sel, input int bound, input bit must, output int k);
        logic ev;
        sfr_wr_en = 1'b0;
        sfr_rd_en = 1'b0;
        k = 0;
        ev = 1'b0;
        while (k < bound && ev !== 1'b1) begin
            @(negedge clk);
            k++;
            ev = sel == 0 ? timer0_event : sel == 1 ? timer1_event : timer3_event;
        end
        if (ev !== 1'b1) begin
            k = 0;
            if (must) begin
                check(16'h0000, 16'h0001);
                test_done();
            end
        end
    endtask
    task automatic classic(input logic [7:0] tm, la, lv, ha, hv, tc, input int k, sel,
        input logic [7:0] ra, re, fe);
        wr(8'h88, 8'h00);
        wr(8'h89, tm);
        wr(la, lv);
        wr(ha, hv);
        wr(8'h88, tc);
        wait_ev(sel, k * 12 + 20, 1'b1, n);
        check(16'(n >= (k - 1) * 12 && n <= k * 12 + 4), 16'h0001);
        rd(ra, rv);
        check(16'(rv), 16'(re));
        rd(8'h88, rv);
        check(16'(rv), 16'(fe));
    endtask
    initial begin
        void'($urandom(32'h12ee5775));
        repeat (8) @(negedge clk);
        reset = 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(regs[i], rv);
            check(16'(rv), 16'h0000);
        end
        $display("test 1 done");
        for (int i = 0; i < 10; i++) begin
            t = (regs[i] == 8'h88) ? ($urandom & 32'hA0) : $urandom;
            wr(regs[i], t[7:0]);
            rd(regs[i], rv);
            check(16'(rv), 16'(t[7:0] & mask[i]));
        end
        for (int i = 0; i < 10; i++) begin
            wr(regs[i], 8'h00);
        end
        $display("test 2 done");
        for (int p = 0; p < 4; p++) begin
            t = $urandom_range(7);
            div = p[1] ? 4 : 12;
            wr(8'h86, t[7:0]);
            wr(8'h84, {5'h00, p[1], p[0], 1'b1});
            wait_ev(3, (t + 1) * div + 30, 1'b1, n);
            check(16'(n >= t * div + 2 && n <= (t + 1) * div + 1), 16'h0001);
            wait_ev(3, (t + 1) * div + 30, p[0], n);
            check(16'(n), 16'(p[0] ? (t + 1) * div : 0));
            rd(8'h84, rv);
            check(16'(rv), {13'h0000, p[1], p[0], p[0]});
        end
        $display("test 3 done");
        wr(8'h86, 8'h14);
        wr(8'h84, 8'h07);
        wait_ev(3, 200, 1'b1, n);
        for (int i = 0; i < 3; i++) begin
            repeat (40) @(negedge clk);
            wr(i == 0 ? 8'h86 : i == 1 ? 8'h84 : 8'h85, i == 0 ? 8'h14 : i == 1 ? 8'h07 : 8'h00);
            wait_ev(3, 200, 1'b1, n);
            check(16'(n >= 80 && n <= 88), 16'h0001);
        end
        wr(8'h84, 8'h06);
        wait_ev(3, 300, 1'b0, n);
        check(16'(n), 16'h0000);
        $display("test 4 done");
        classic(8'h01, 8'h8A, 8'hFF, 8'h8C, 8'hFF, 8'h10, 1, 0, 8'h8C, 8'h00, 8'h30);
        classic(8'h00, 8'h8A, 8'hFF, 8'h8C, 8'hFF, 8'h10, 1, 0, 8'h8A, 8'hE0, 8'h30);
        classic(8'h02, 8'h8A, 8'hFD, 8'h8C, 8'hF0, 8'h10, 3, 0, 8'h8A, 8'hF0, 8'h30);
        classic(8'h03, 8'h8A, 8'h00, 8'h8C, 8'hFE, 8'h40, 2, 1, 8'h8C, 8'h00, 8'hC0);
        classic(8'h20, 8'h8B, 8'hFE, 8'h8D, 8'hFE, 8'h40, 2, 1, 8'h8B, 8'hFE, 8'hC0);
        classic(8'h10, 8'h8B, 8'hFF, 8'h8D, 8'hFF, 8'h40, 1, 1, 8'h8D, 8'h00, 8'hC0);
        classic(8'h33, 8'h8B, 8'h5A, 8'h8C, 8'hFF, 8'h40, 1, 1, 8'h8B, 8'h5A, 8'hC0);
        $display("test 5 done");
        test_done();
    end
endmodule
`default_nettype wire
